// file: design/sram_pkg.sv
/*
 Shared constants and packed carriers for the pipelined burst memory
 and its transfer log FIFO. Assumes one clock domain at 250 MHz.
*/
package sram_pkg;
	localparam int ADDR_W = 17;
	localparam int WORDS = 131072;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int MAIN_LANE_W = 8;
	localparam int DATA_W = LANES * LANE_W;
	localparam int MAIN_W = LANES * MAIN_LANE_W;
	localparam int BEAT_W = 2;
	localparam int LOG_DEPTH = 8;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
	localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
	localparam logic [LANES-1:0] LANES_OFF = 4'hf;

	typedef enum logic [1:0] {
		BURST_IDLE,
		BURST_READ,
		BURST_WRITE
	} burst_st_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_wr_n;
	} req_t;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} xfer_t;

	localparam int XFER_W = $bits(xfer_t);
endpackage

// file: design/stream_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two; reads and writes share sys_clk.
*/
`timescale 1ns/1ns
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PTR_W:0] wr_ptr_r, wr_ptr_nxt;
	logic [PTR_W:0] rd_ptr_r, rd_ptr_nxt;
	logic full, empty, push, pop;

	// Extra pointer bit tells full from empty without a counter
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) && (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign push = in_valid & ~full;
	assign pop = out_ready & ~empty;
	assign out_data = store[rd_ptr_r[PTR_W-1:0]];

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		if (push) begin
			wr_ptr_nxt = wr_ptr_r + 1'b1;
		end
		if (pop) begin
			rd_ptr_nxt = rd_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			store[wr_ptr_r[PTR_W-1:0]] <= in_data;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (srst)
		full |-> !in_ready ##1 $stable(wr_ptr_r))
		else $error("fifo accepted a word while full");
endmodule // stream_fifo

// file: design/burst_sram.sv
/*
 Pipelined synchronous 128K x 36 memory with a four-beat burst counter,
 triple chip select, clock suspend and per-lane write enables. Every
 completed transfer is also logged through an 8-word FIFO.
 Assumes all inputs synchronous to sys_clk except out_en_n; the data
 pins are resolved outside from the output enables.
*/
`timescale 1ns/1ns
module burst_sram
	import sram_pkg::*;
#(
	parameter int LOG_WORDS = sram_pkg::LOG_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Control
	input wire logic clk_hold_n,
	input wire logic advance_or_load,
	input wire logic read_not_write,
	input wire logic chip_sel_a_n,
	input wire logic chip_sel_b,
	input wire logic chip_sel_c_n,
	input wire logic out_en_n,
	input wire logic burst_order_sel,
	// Address and lane enables
	input wire logic [sram_pkg::ADDR_W-1:0] word_addr,
	input wire logic [sram_pkg::LANES-1:0] byte_lane_wr_n,
	// Data pins
	input wire logic [sram_pkg::MAIN_W-1:0] dq_main_in,
	output logic [sram_pkg::MAIN_W-1:0] dq_main_out,
	output logic dq_main_oe,
	input wire logic [sram_pkg::LANES-1:0] dq_parity_in,
	output logic [sram_pkg::LANES-1:0] dq_parity_out,
	output logic dq_parity_oe,
	// Transfer log stream
	output logic log_valid,
	input wire logic log_ready,
	output sram_pkg::xfer_t log_data
);
	import sram_pkg::*;

	burst_st_t burst_st_r, burst_st_nxt;
	logic [ADDR_W-1:0] base_r, base_nxt;
	logic [BEAT_W-1:0] beat_r, beat_nxt;
	req_t s1_r, s1_nxt;
	req_t s2_r, s2_nxt;
	logic drive_r, drive_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;

	logic selected, stall, log_in_ready, push_valid;
	logic [BEAT_W-1:0] beat_inc, beat_sel;
	logic [DATA_W-1:0] rd_word, wr_word, wr_mask;
	xfer_t push_data;

	// All three selects must be active together
	assign selected = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
	// A full log behaves exactly like a held clock so no transfer is lost
	assign stall = clk_hold_n | ~log_in_ready;

	assign beat_inc = beat_r + BEAT_STEP;
	// Only the low two address bits move during a burst
	assign beat_sel = burst_order_sel ? (base_r[BEAT_W-1:0] ^ beat_inc)
		: (base_r[BEAT_W-1:0] + beat_inc);

	// Lane i is data byte i with its parity bit on top
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			logic [LANE_W-1:0] mem [WORDS];
			logic fwd_hit;

			assign wr_word[gi*LANE_W +: LANE_W] = {dq_parity_in[gi], dq_main_in[gi*MAIN_LANE_W +: MAIN_LANE_W]};
			assign wr_mask[gi*LANE_W +: LANE_W] = {LANE_W{~s2_r.lane_wr_n[gi]}};
			// A write landing on this same edge is forwarded, so a read right behind it sees the new lane
			assign fwd_hit = s2_r.valid && s2_r.write && !s2_r.lane_wr_n[gi] && (s2_r.addr == s1_r.addr);
			assign rd_word[gi*LANE_W +: LANE_W] = fwd_hit ? wr_word[gi*LANE_W +: LANE_W]
				: mem[s1_r.addr];
			assign dq_main_out[gi*MAIN_LANE_W +: MAIN_LANE_W] = dout_r[gi*LANE_W +: MAIN_LANE_W];
			assign dq_parity_out[gi] = dout_r[gi*LANE_W + MAIN_LANE_W];

			// Write data is sampled in the third cycle of the request
			always_ff @(posedge sys_clk) begin
				if (!stall && s2_r.valid && s2_r.write && !s2_r.lane_wr_n[gi]) begin
					mem[s2_r.addr] <= wr_word[gi*LANE_W +: LANE_W];
				end
			end
		end
	endgenerate

	always_comb begin
		burst_st_nxt = burst_st_r;
		base_nxt = base_r;
		beat_nxt = beat_r;
		s1_nxt = '0;
		s2_nxt = s1_r;
		drive_nxt = s1_r.valid & ~s1_r.write;
		dout_nxt = dout_r;
		if (stall) begin
			s1_nxt = s1_r;
			s2_nxt = s2_r;
			drive_nxt = drive_r;
		end else begin
			if (!advance_or_load) begin
				if (selected) begin
					base_nxt = word_addr;
					beat_nxt = BEAT_FIRST;
					burst_st_nxt = read_not_write ? BURST_READ : BURST_WRITE;
					s1_nxt.valid = 1'b1;
					s1_nxt.write = ~read_not_write;
					s1_nxt.addr = word_addr;
					s1_nxt.lane_wr_n = read_not_write ? LANES_OFF : byte_lane_wr_n;
				end else begin
					burst_st_nxt = BURST_IDLE;
				end
			end else begin
				case (burst_st_r)
					BURST_READ, BURST_WRITE: begin
						// External address is ignored while advancing
						beat_nxt = beat_inc;
						s1_nxt.valid = 1'b1;
						s1_nxt.write = (burst_st_r == BURST_WRITE);
						s1_nxt.addr = {base_r[ADDR_W-1:BEAT_W], beat_sel};
						s1_nxt.lane_wr_n = (burst_st_r == BURST_WRITE) ? byte_lane_wr_n : LANES_OFF;
						if (beat_inc == BEAT_LAST) begin
							burst_st_nxt = BURST_IDLE;
						end
					end
					default: begin
						burst_st_nxt = BURST_IDLE;
					end
				endcase
			end
			// Read data leaves one edge early so it stands in the cycle where write data would
			if (s1_r.valid && !s1_r.write) begin
				dout_nxt = rd_word;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burst_st_r <= BURST_IDLE;
			base_r <= '0;
			beat_r <= BEAT_FIRST;
			s1_r <= '0;
			s2_r <= '0;
			drive_r <= 1'b0;
			dout_r <= '0;
		end else begin
			burst_st_r <= burst_st_nxt;
			base_r <= base_nxt;
			beat_r <= beat_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			drive_r <= drive_nxt;
			dout_r <= dout_nxt;
		end
	end

	// Output enable bypasses the pipeline entirely
	assign dq_main_oe = drive_r & ~out_en_n;
	assign dq_parity_oe = drive_r & ~out_en_n;

	// Log every completed transfer; stalls the pipeline when the log is full
	assign push_valid = s2_r.valid & ~clk_hold_n;
	always_comb begin
		push_data.write = s2_r.write;
		push_data.addr = s2_r.addr;
		// A read's word already sits in dout_r while the read is in stage two
		push_data.data = s2_r.write ? wr_word : dout_r;
	end

	stream_fifo #(
		.WIDTH(XFER_W),
		.DEPTH(LOG_WORDS)
	) u_log (
		.sys_clk(sys_clk),
		.srst(srst),
		.in_valid(push_valid),
		.in_ready(log_in_ready),
		.in_data(push_data),
		.out_valid(log_valid),
		.out_ready(log_ready),
		.out_data(log_data)
	);

	// Helper view of the inputs as the pipeline sees them
	logic load_rd, load_wr, desel, adv_run;
	assign load_rd = !stall && !advance_or_load && selected && read_not_write;
	assign load_wr = !stall && !advance_or_load && selected && !read_not_write;
	assign desel = !stall && !advance_or_load && !selected;
	assign adv_run = !stall && advance_or_load && (burst_st_r != BURST_IDLE);
	logic rd_after_wr, adv_idle;
	logic [BEAT_W-1:0] low_base;
	assign rd_after_wr = !stall && s1_r.valid && !s1_r.write && s2_r.valid && s2_r.write
		&& (s2_r.addr == s1_r.addr);
	assign adv_idle = !stall && advance_or_load && (burst_st_r == BURST_IDLE);
	assign low_base = base_r[BEAT_W-1:0];

	// Request taken, then one more edge that is not held
	sequence s_issue(ev);
		ev ##1 !stall;
	endsequence

	a_read_latency: assert property (@(posedge sys_clk) disable iff (srst)
		s_issue(load_rd) |=> drive_r && $past(s1_r.valid) && !$past(s1_r.write))
		else $error("read did not drive data two edges after capture");

	a_write_release: assert property (@(posedge sys_clk) disable iff (srst)
		s_issue(load_wr) |=> !drive_r)
		else $error("bus not released two cycles after a write");

	a_desel_release: assert property (@(posedge sys_clk) disable iff (srst)
		s_issue(desel) |=> !drive_r)
		else $error("bus not released two cycles after a deselect");

	a_rw_forward: assert property (@(posedge sys_clk) disable iff (srst)
		rd_after_wr |=> (dout_r & $past(wr_mask)) == ($past(wr_word) & $past(wr_mask)))
		else $error("read behind a write missed the new lanes");

	// Write data and read data share the pins, so a write in stage two must find them released
	a_no_contention: assert property (@(posedge sys_clk) disable iff (srst)
		s2_r.valid && s2_r.write |-> !drive_r)
		else $error("data pins driven while write data is due");

	a_order_linear: assert property (@(posedge sys_clk) disable iff (srst)
		adv_run && !burst_order_sel
		|=> s1_r.addr[BEAT_W-1:0] == BEAT_W'($past(low_base) + $past(beat_r) + BEAT_STEP))
		else $error("linear burst stepped to the wrong word");

	a_order_inter: assert property (@(posedge sys_clk) disable iff (srst)
		adv_run && burst_order_sel
		|=> s1_r.addr[BEAT_W-1:0] == ($past(low_base) ^ BEAT_W'($past(beat_r) + BEAT_STEP)))
		else $error("interleaved burst stepped to the wrong word");

	a_write_lanes: assert property (@(posedge sys_clk) disable iff (srst)
		load_wr |=> s1_r.write && s1_r.lane_wr_n == $past(byte_lane_wr_n))
		else $error("write lane enables not captured");

	a_adv_after_end: assert property (@(posedge sys_clk) disable iff (srst)
		adv_idle |=> !s1_r.valid)
		else $error("advance without a running burst started a transfer");

	a_hold_control: assert property (@(posedge sys_clk) disable iff (srst)
		stall |=> $stable(burst_st_r) && $stable(base_r))
		else $error("burst control changed during clock hold");

	a_desel_pending: assert property (@(posedge sys_clk) disable iff (srst)
		desel && s1_r.valid |=> s2_r.valid && s2_r.addr == $past(s1_r.addr))
		else $error("deselect dropped a pending transfer");

	a_hold_freeze: assert property (@(posedge sys_clk) disable iff (srst)
		stall |=> $stable(s1_r) && $stable(s2_r) && $stable(dout_r) && $stable(drive_r) && $stable(beat_r))
		else $error("state changed during clock hold");

	a_addr_load: assert property (@(posedge sys_clk) disable iff (srst)
		(load_rd || load_wr) |=> s1_r.valid && s1_r.addr == $past(word_addr) && beat_r == BEAT_FIRST)
		else $error("address not loaded on select");

	a_desel_stop: assert property (@(posedge sys_clk) disable iff (srst)
		desel |=> burst_st_r == BURST_IDLE && !s1_r.valid)
		else $error("deselect did not stop the burst");

	a_burst_base: assert property (@(posedge sys_clk) disable iff (srst)
		adv_run |=> s1_r.valid && s1_r.addr[ADDR_W-1:BEAT_W] == $past(base_r[ADDR_W-1:BEAT_W]))
		else $error("advance changed the upper address bits");

	a_burst_length: assert property (@(posedge sys_clk) disable iff (srst)
		(load_rd || load_wr) ##1 adv_run ##1 adv_run ##1 adv_run |=> burst_st_r == BURST_IDLE)
		else $error("burst ran past four beats");

	a_read_lanes: assert property (@(posedge sys_clk) disable iff (srst)
		load_rd |=> s1_r.lane_wr_n == LANES_OFF && !s1_r.write)
		else $error("lane enables not ignored on a read");

	a_oe_async: assert property (@(posedge sys_clk) disable iff (srst)
		out_en_n |-> !dq_main_oe && !dq_parity_oe)
		else $error("outputs driven with output enable high");
endmodule // burst_sram

// file: sim/host_ctrl.sv
/*
 Host controller model for burst_sram: loads, advances, deselects, holds.
 Assumes the bench seeds the generator and picks the phase through mode.
*/
`timescale 1ns/1ns
module host_ctrl
	import sram_pkg::*;
(
	// Clock and phase: 0 fill, 1 random, 2 idle
	input wire logic sys_clk,
	input wire logic [1:0] mode,
	input wire logic order,
	// Memory pins
	output logic clk_hold_n = 1'b0,
	output logic advance_or_load = 1'b0,
	output logic read_not_write = 1'b0,
	output logic chip_sel_a_n = 1'b1,
	output logic chip_sel_b = 1'b0,
	output logic chip_sel_c_n = 1'b1,
	output logic out_en_n = 1'b0,
	output logic burst_order_sel = 1'b0,
	output logic [sram_pkg::ADDR_W-1:0] word_addr = '0,
	output logic [sram_pkg::LANES-1:0] byte_lane_wr_n = '0,
	output logic [sram_pkg::MAIN_W-1:0] dq_main_in = '0,
	output logic [sram_pkg::LANES-1:0] dq_parity_in = '0
);
	logic [4:0] cnt = '0;
	logic rnd;
	always @(posedge sys_clk) begin
		#1;
		rnd = mode == 2'h1;
		// Fresh value every cycle, so a released bus never shows stale data
		dq_main_in = $urandom;
		dq_parity_in = 4'($urandom);
		burst_order_sel = order;
		byte_lane_wr_n = rnd ? 4'($urandom) : 4'h0;
		word_addr = {13'h1fff, rnd ? 4'($urandom) : cnt[3:0]};
		clk_hold_n = rnd && ($urandom % 8 == 0);
		out_en_n = rnd && ($urandom % 8 == 0);
		advance_or_load = rnd && ($urandom % 2 == 0);
		read_not_write = rnd && ($urandom % 2 == 0);
		if (mode == 2'h2 || cnt[4] || (rnd && $urandom % 8 == 0))
			{chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 3'h2 ^ 3'(3'h1 << ($urandom % 3));
		else
			{chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 3'h2;
		if (mode != 2'h0)
			cnt = 5'h0;
		else if (!cnt[4])
			cnt = cnt + 5'h1;
	end
endmodule // host_ctrl

// file: sim/tb_top.sv
/*
 Self-checking bench for burst_sram with a pipeline reference model.
 Assumes host_ctrl drives the pins; all words live in one 16-word region.
*/
`timescale 1ns/1ns
module tb_top;
	import sram_pkg::*;
	logic sys_clk = 1'b0;
	logic srst, log_ready, order, log_valid, main_oe, par_oe, st;
	logic clk_hold_n, advance_or_load, read_not_write, out_en_n, burst_order_sel;
	logic chip_sel_a_n, chip_sel_b, chip_sel_c_n;
	logic [1:0] mode, beat, a2;
	logic [ADDR_W-1:0] word_addr, base;
	logic [LANES-1:0] byte_lane_wr_n, host_par, par_out, par_w;
	logic [MAIN_W-1:0] host_main, main_out, main_w;
	logic [DATA_W-1:0] din, dseen, dq_e;
	logic [DATA_W-1:0] mem [16];
	logic drv = 1'b0;
	logic run = 1'b0;
	logic bwr;
	xfer_t log_data;
	xfer_t q[$];
	req_t s1, s2, nr;
	int n_errors = 0;
	int n_checks = 0;
	int i, k;
	// Wire level: the device wins while it drives, else the host
	assign main_w = main_oe ? main_out : host_main;
	assign par_w = par_oe ? par_out : host_par;
	always #2 sys_clk = ~sys_clk;
	host_ctrl host_ctrl_i (.sys_clk, .mode, .order, .clk_hold_n, .advance_or_load, .read_not_write,
		.chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .out_en_n, .burst_order_sel, .word_addr,
		.byte_lane_wr_n, .dq_main_in(host_main), .dq_parity_in(host_par));
	burst_sram #(.LOG_WORDS(LOG_DEPTH)) burst_sram_i (.sys_clk, .srst, .clk_hold_n, .advance_or_load,
		.read_not_write, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .out_en_n, .burst_order_sel,
		.word_addr, .byte_lane_wr_n, .dq_main_in(main_w), .dq_main_out(main_out), .dq_main_oe(main_oe),
		.dq_parity_in(par_w), .dq_parity_out(par_out), .dq_parity_oe(par_oe), .log_valid, .log_ready,
		.log_data);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic run_for(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	always @(posedge sys_clk) begin
		for (i = 0; i < LANES; i++) begin
			din[9*i+:9] = {par_w[i], main_w[8*i+:8]};
			dseen[9*i+:9] = {par_out[i], main_out[8*i+:8]};
		end
		// A full log holds the device as a clock hold would
		st = clk_hold_n || q.size() == LOG_DEPTH;
		if (!srst) begin
			chk(main_oe, drv & ~out_en_n);
			chk(par_oe, drv & ~out_en_n);
			if (drv)
				chk(dseen, dq_e);
			chk(log_valid, q.size() != 0);
			if (q.size() != 0) begin
				chk({log_data.write, log_data.addr}, {q[0].write, q[0].addr});
				chk(log_data.data, q[0].data);
				if (log_ready)
					void'(q.pop_front());
			end
		end
		if (srst) begin
			s1 = '0;
			s2 = '0;
			run = 1'b0;
			drv = 1'b0;
			q.delete();
		end else if (!st) begin
			// Log first: a read's word already stands in dq_e while it sits in stage two
			if (s2.valid)
				q.push_back(xfer_t'{s2.write, s2.addr, s2.write ? din : dq_e});
			if (s2.valid && s2.write)
				for (i = 0; i < LANES; i++)
					if (!s2.lane_wr_n[i])
						mem[s2.addr[3:0]][9*i+:9] = din[9*i+:9];
			// The write lands before the read behind it looks, so no dead cycle is needed
			if (s1.valid && !s1.write)
				dq_e = mem[s1.addr[3:0]];
			drv = s1.valid && !s1.write;
			nr = '0;
			if (!advance_or_load) begin
				run = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
				base = word_addr;
				beat = 2'h0;
				bwr = !read_not_write;
				if (run)
					nr = '{1'b1, bwr, base, byte_lane_wr_n};
			end else if (run && beat != 2'h3) begin
				beat++;
				a2 = burst_order_sel ? base[1:0] ^ beat : base[1:0] + beat;
				nr = '{1'b1, bwr, {base[ADDR_W-1:2], a2}, byte_lane_wr_n};
			end else
				run = 1'b0;
			s2 = s1;
			s1 = nr;
		end
	end
	initial begin
		srst = 1'b1;
		log_ready = 1'b1;
		order = 1'b0;
		mode = 2'h2;
		void'($urandom(32'h092d8676));
		repeat (20) @(posedge sys_clk);
		#1 srst = 1'b0;
		// Linear order first, then a mid-run reset and interleaved order
		for (k = 0; k < 2; k++) begin
			mode = 2'h0;
			run_for(24);
			mode = 2'h1;
			run_for(300);
			log_ready = 1'b0;
			run_for(40);
			log_ready = 1'b1;
			run_for(300);
			mode = 2'h2;
			run_for(4);
			order = 1'b1;
			srst = 1'b1;
			run_for(3);
			srst = 1'b0;
		end
		stop_test();
	end
endmodule // tb_top
